//--- hw/ttf_params.svh
`ifndef TTF_PARAMS_SVH
`define TTF_PARAMS_SVH

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define TTF_CMD_WRITE_FAMILY    6'h0D
`define TTF_CMD_LOCK_FAMILY     6'h0E

// ----------------------------------------------------------------
// frame layout, first received bit is the msb of the header
// ----------------------------------------------------------------
`define TTF_HDR_BITS            7'h10
`define TTF_HDR_EXT_BIT         15
`define TTF_HDR_CODE_HI         14
`define TTF_HDR_CODE_LO         9
`define TTF_HDR_FLAG_BIT        8
`define TTF_SERIAL_BITS         40
`define TTF_FAMILY_BITS         8
`define TTF_MAX_FRAME_BITS      80
`define TTF_AT_SERIAL_DONE      7'h38
`define TTF_AT_FAMILY_SERIAL    7'h40
`define TTF_AT_FAMILY_PLAIN     7'h18
`define TTF_LEN_WR_SERIAL       7'h50
`define TTF_LEN_WR_PLAIN        7'h28
`define TTF_LEN_LK_SERIAL       7'h48
`define TTF_LEN_LK_PLAIN        7'h10

// ----------------------------------------------------------------
// reply error codes
// ----------------------------------------------------------------
`define TTF_ERR_NOT_SUPPORTED   8'h01
`define TTF_ERR_LOCKED          8'h0F

// ----------------------------------------------------------------
// register offsets, fields and reset values
// ----------------------------------------------------------------
`define TTF_OFF_CTRL            8'h00
`define TTF_OFF_SERIAL_LO       8'h04
`define TTF_OFF_SERIAL_HI       8'h08
`define TTF_OFF_FAMILY          8'h0C
`define TTF_OFF_REPLY           8'h10
`define TTF_CTRL_WR_EN_BIT      0
`define TTF_CTRL_LK_EN_BIT      1
`define TTF_FAMILY_LOCK_BIT     8
`define TTF_CTRL_RESET          2'h3
`define TTF_SERIAL_RESET        40'h00_0000_0000
`define TTF_FAMILY_RESET        8'h00

`endif

//--- hw/ttf_pkg.sv
`default_nettype none
package ttf_pkg;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        TTF_READY,
        TTF_QUIET,
        TTF_SELECTED,
        TTF_ROUND_ACTIVE,
        TTF_ROUND_STANDBY
    } ttf_tag_state_e;

    typedef struct packed {
        logic bit_valid;
        logic bit_data;
        logic frame_end;
        logic hdr_crc_ok;
        logic body_crc_ok;
    } ttf_frame_in_s;

    typedef struct packed {
        logic       error;
        logic [7:0] code;
    } ttf_reply_s;

endpackage
`default_nettype wire

//--- hw/ttf_bit_shifter.sv
`timescale 1ns/1ns
`default_nettype none
module ttf_bit_shifter #(
    parameter int WIDTH    = 40,
    parameter int CNT_W    = 7,
    parameter int MAX_BITS = 80
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    // serial bits
    input  wire logic             bit_valid_in,
    input  wire logic             bit_data_in,
    input  wire logic             clear_in,
    // collected bits
    output logic [WIDTH-1:0] data_out,
    output logic [CNT_W-1:0] count_out,
    output logic             overflow_out
);
    logic [WIDTH-1:0] data_reg;
    logic [WIDTH-1:0] data_next;
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    localparam logic [CNT_W-1:0] SAT = CNT_W'(MAX_BITS + 1);

    // count saturates one past the longest frame so overlong frames show
    always_comb begin
        data_next  = data_reg;
        count_next = count_reg;
        if (clear_in) begin
            data_next  = '0;
            count_next = '0;
        end else if (bit_valid_in) begin
            data_next = {data_reg[WIDTH-2:0], bit_data_in};
            if (count_reg != SAT) begin
                count_next = count_reg + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            data_reg  <= '0;
            count_reg <= '0;
        end else begin
            data_reg  <= data_next;
            count_reg <= count_next;
        end
    end

    assign data_out     = data_reg;
    assign count_out    = count_reg;
    assign overflow_out = (count_reg == SAT);
endmodule
`default_nettype wire

//--- hw/ttf_reply_drive.sv
`timescale 1ns/1ns
`default_nettype none
module ttf_reply_drive (
    // clock and reset
    input  wire logic               clk_in,
    input  wire logic               rst_n_in,
    // reply decision
    input  wire logic               fire_in,
    input  wire ttf_pkg::ttf_reply_s reply_in,
    // registered reply
    output logic                    valid_out,
    output ttf_pkg::ttf_reply_s     reply_out
);
    import ttf_pkg::*;

    logic       valid_reg;
    logic       valid_next;
    ttf_reply_s reply_reg;
    ttf_reply_s reply_next;

    // reply fields hold until the next reply so the modulator may read late
    always_comb begin
        valid_next = fire_in;
        reply_next = fire_in ? reply_in : reply_reg;
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            valid_reg <= 1'b0;
            reply_reg <= '0;
        end else begin
            valid_reg <= valid_next;
            reply_reg <= reply_next;
        end
    end

    assign valid_out = valid_reg;
    assign reply_out = reply_reg;
endmodule
`default_nettype wire

//--- hw/ttf_family_cmd.sv
`timescale 1ns/1ns
`default_nettype none
`include "ttf_params.svh"
// How it works
// - write command stores received family byte
// - lock command freezes family byte until reset
// - serial write frame: header, serial, byte, crc
// - plain write frame: header, byte, crc
// - serial lock frame: header, serial, crc
// - plain lock frame ends after header
// - addressed but unsupported gives error one
// - supported but failed gives error reply
// - executed command gives plain success reply
// - tags not addressed stay silent
// - unselected states ignore mismatched serial
// - unselected states execute on serial match
// - selected executes plain or matching frames
module ttf_family_cmd (
    // clock and reset
    input  wire logic                    CORE_CLK_IN,
    input  wire logic                    RESET_N_IN,
    // wishbone slave
    input  wire logic                    WB_CYC_IN,
    input  wire logic                    WB_STB_IN,
    input  wire logic                    WB_WE_IN,
    input  wire logic [7:0]              WB_ADR_IN,
    input  wire logic [3:0]              WB_SEL_IN,
    input  wire logic [31:0]             WB_DAT_IN,
    output logic [31:0]                  WB_DAT_OUT,
    output logic                         WB_ACK_OUT,
    // demodulated frame and tag state
    input  wire ttf_pkg::ttf_frame_in_s  FRAME_IN,
    input  wire ttf_pkg::ttf_tag_state_e TAG_STATE_IN,
    // reply to the modulator
    output logic                         REPLY_VALID_OUT,
    output var ttf_pkg::ttf_reply_s      REPLY_OUT,
    // stored family byte
    output logic [7:0]                   FAMILY_OUT,
    output logic                         FAMILY_LOCKED_OUT
);
    import ttf_pkg::*;

    // ----------------------------------------------------------------
    // types and declarations
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_RECV,
        ST_EXEC,
        ST_DROP
    } ttf_dec_e;

    ttf_dec_e       dec_state_reg;
    ttf_dec_e       dec_state_next;
    logic [15:0]    hdr_reg;
    logic [15:0]    hdr_next;
    logic [39:0]    serial_rx_reg;
    logic [39:0]    serial_rx_next;
    logic [7:0]     fam_rx_reg;
    logic [7:0]     fam_rx_next;
    logic [6:0]     len_reg;
    logic [6:0]     len_next;
    logic           hdr_ok_reg;
    logic           hdr_ok_next;
    logic           body_ok_reg;
    logic           body_ok_next;
    ttf_tag_state_e tag_state_reg;
    ttf_tag_state_e tag_state_next;

    logic [7:0]     family_reg;
    logic [7:0]     family_next;
    logic           locked_reg;
    logic           locked_next;
    logic [10:0]    status_reg;
    logic [10:0]    status_next;

    logic [1:0]     ctrl_reg;
    logic [1:0]     ctrl_next;
    logic [39:0]    serial_id_reg;
    logic [39:0]    serial_id_next;
    logic           ack_reg;
    logic           ack_next;
    logic [31:0]    rdata_reg;
    logic [31:0]    rdata_next;
    logic [31:0]    ctrl_merge;
    logic [31:0]    ser_hi_merge;

    logic [39:0]    shift_data;
    logic [6:0]     shift_count;
    logic           shift_over;
    logic           shift_clear;

    logic           is_write;
    logic           is_lock;
    logic           flag;
    logic           frame_ok;
    logic           serial_match;
    logic           addressed;
    logic           supported;
    logic           fire;
    ttf_reply_s     reply;
    logic           do_write;
    logic           do_lock;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // expected frame length per command and format
    function automatic logic [6:0] frame_len(input logic wr, input logic with_serial);
        if (wr) begin
            frame_len = with_serial ? `TTF_LEN_WR_SERIAL : `TTF_LEN_WR_PLAIN;
        end else begin
            frame_len = with_serial ? `TTF_LEN_LK_SERIAL : `TTF_LEN_LK_PLAIN;
        end
    endfunction

    // byte-lane merge for wishbone writes
    function automatic logic [31:0] lane_merge(input logic [31:0] old_val, input logic [31:0] new_val,
                                               input logic [3:0] sel);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        lane_merge = res;
    endfunction

    // ----------------------------------------------------------------
    // bit collection
    // ----------------------------------------------------------------
    assign shift_clear = (dec_state_reg == ST_EXEC);

    ttf_bit_shifter #(
        .WIDTH    (`TTF_SERIAL_BITS),
        .CNT_W    (7),
        .MAX_BITS (`TTF_MAX_FRAME_BITS)
    ) u_shift (
        .clk_in       (CORE_CLK_IN),
        .rst_n_in     (RESET_N_IN),
        .bit_valid_in (FRAME_IN.bit_valid),
        .bit_data_in  (FRAME_IN.bit_data),
        .clear_in     (shift_clear),
        .data_out     (shift_data),
        .count_out    (shift_count),
        .overflow_out (shift_over)
    );

    // ----------------------------------------------------------------
    // frame decision
    // ----------------------------------------------------------------
    always_comb begin
        flag      = hdr_reg[`TTF_HDR_FLAG_BIT];
        is_write  = !hdr_reg[`TTF_HDR_EXT_BIT]
                    && (hdr_reg[`TTF_HDR_CODE_HI:`TTF_HDR_CODE_LO] == `TTF_CMD_WRITE_FAMILY);
        is_lock   = !hdr_reg[`TTF_HDR_EXT_BIT]
                    && (hdr_reg[`TTF_HDR_CODE_HI:`TTF_HDR_CODE_LO] == `TTF_CMD_LOCK_FAMILY);
        // length per format
        // plain lock frame has no body, so only the header crc counts
        frame_ok  = (is_write || is_lock) && hdr_ok_reg
                    && (len_reg == frame_len(is_write, flag))
                    && (body_ok_reg || (len_reg == `TTF_HDR_BITS));
        serial_match = (serial_rx_reg == serial_id_reg);
        if (flag) begin
            addressed = serial_match;
        end else begin
            addressed = (tag_state_reg == TTF_SELECTED);
        end
        supported = is_write ? ctrl_reg[`TTF_CTRL_WR_EN_BIT] : ctrl_reg[`TTF_CTRL_LK_EN_BIT];
        fire      = (dec_state_reg == ST_EXEC) && frame_ok && addressed;
        reply     = '0;
        do_write  = 1'b0;
        do_lock   = 1'b0;
        if (!supported) begin
            reply.error = 1'b1;
            reply.code  = `TTF_ERR_NOT_SUPPORTED;
        end else if (locked_reg) begin
            reply.error = 1'b1;
            reply.code  = `TTF_ERR_LOCKED;
        end else begin
            do_write = fire && is_write;
            do_lock  = fire && is_lock;
        end
    end

    // ----------------------------------------------------------------
    // receive state machine
    // ----------------------------------------------------------------
    always_comb begin
        dec_state_next = dec_state_reg;
        hdr_next       = hdr_reg;
        serial_rx_next = serial_rx_reg;
        fam_rx_next    = fam_rx_reg;
        len_next       = len_reg;
        hdr_ok_next    = hdr_ok_reg;
        body_ok_next   = body_ok_reg;
        tag_state_next = tag_state_reg;
        case (dec_state_reg)
            ST_RECV: begin
                if (shift_count == `TTF_HDR_BITS) begin
                    hdr_next = shift_data[15:0];
                end
                if (hdr_reg[`TTF_HDR_FLAG_BIT] && (shift_count == `TTF_AT_SERIAL_DONE)) begin
                    serial_rx_next = shift_data;
                end
                if ((hdr_reg[`TTF_HDR_FLAG_BIT] && (shift_count == `TTF_AT_FAMILY_SERIAL))
                    || (!hdr_reg[`TTF_HDR_FLAG_BIT] && (shift_count == `TTF_AT_FAMILY_PLAIN))) begin
                    fam_rx_next = shift_data[7:0];
                end
                if (shift_over) begin
                    dec_state_next = ST_DROP;
                end else if (FRAME_IN.frame_end) begin
                    len_next       = shift_count;
                    hdr_ok_next    = FRAME_IN.hdr_crc_ok;
                    body_ok_next   = FRAME_IN.body_crc_ok;
                    tag_state_next = TAG_STATE_IN;
                    dec_state_next = ST_EXEC;
                end
            end
            ST_EXEC: begin
                // stale fields would make a short frame look complete
                hdr_next       = '0;
                serial_rx_next = '0;
                fam_rx_next    = '0;
                dec_state_next = ST_RECV;
            end
            ST_DROP: begin
                len_next = '0;
                if (FRAME_IN.frame_end) begin
                    dec_state_next = ST_EXEC;
                end
            end
            default: begin
                dec_state_next = ST_RECV;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (!RESET_N_IN) begin
            dec_state_reg <= ST_RECV;
            hdr_reg       <= '0;
            serial_rx_reg <= '0;
            fam_rx_reg    <= '0;
            len_reg       <= '0;
            hdr_ok_reg    <= 1'b0;
            body_ok_reg   <= 1'b0;
            tag_state_reg <= TTF_READY;
        end else begin
            dec_state_reg <= dec_state_next;
            hdr_reg       <= hdr_next;
            serial_rx_reg <= serial_rx_next;
            fam_rx_reg    <= fam_rx_next;
            len_reg       <= len_next;
            hdr_ok_reg    <= hdr_ok_next;
            body_ok_reg   <= body_ok_next;
            tag_state_reg <= tag_state_next;
        end
    end

    // ----------------------------------------------------------------
    // family byte storage
    // ----------------------------------------------------------------
    always_comb begin
        family_next = family_reg;
        locked_next = locked_reg;
        status_next = status_reg;
        if (do_write) begin
            family_next = fam_rx_reg;
        end
        // permanent lock, only reset clears it
        if (do_lock) begin
            locked_next = 1'b1;
        end
        if (fire) begin
            status_next = {reply.code, 1'b0, reply.error, 1'b1};
        end else if (dec_state_reg == ST_EXEC) begin
            status_next = {status_reg[10:2], 1'b0, 1'b0} | 11'h004;
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (!RESET_N_IN) begin
            family_reg <= `TTF_FAMILY_RESET;
            locked_reg <= 1'b0;
            status_reg <= '0;
        end else begin
            family_reg <= family_next;
            locked_reg <= locked_next;
            status_reg <= status_next;
        end
    end

    ttf_reply_drive u_reply (
        .clk_in    (CORE_CLK_IN),
        .rst_n_in  (RESET_N_IN),
        .fire_in   (fire),
        .reply_in  (reply),
        .valid_out (REPLY_VALID_OUT),
        .reply_out (REPLY_OUT)
    );

    // ----------------------------------------------------------------
    // wishbone registers
    // ----------------------------------------------------------------
    always_comb begin
        ctrl_next      = ctrl_reg;
        serial_id_next = serial_id_reg;
        rdata_next     = rdata_reg;
        ack_next       = WB_CYC_IN && WB_STB_IN && !ack_reg;
        ctrl_merge     = lane_merge({30'h0, ctrl_reg}, WB_DAT_IN, WB_SEL_IN);
        ser_hi_merge   = lane_merge({24'h0, serial_id_reg[39:32]}, WB_DAT_IN, WB_SEL_IN);
        if (ack_next) begin
            rdata_next = 32'h0000_0000;
            case (WB_ADR_IN)
                `TTF_OFF_CTRL: begin
                    rdata_next[1:0] = ctrl_reg;
                    if (WB_WE_IN) begin
                        ctrl_next = ctrl_merge[1:0];
                    end
                end
                `TTF_OFF_SERIAL_LO: begin
                    rdata_next = serial_id_reg[31:0];
                    if (WB_WE_IN) begin
                        serial_id_next[31:0] = lane_merge(serial_id_reg[31:0], WB_DAT_IN, WB_SEL_IN);
                    end
                end
                `TTF_OFF_SERIAL_HI: begin
                    rdata_next[7:0] = serial_id_reg[39:32];
                    if (WB_WE_IN) begin
                        serial_id_next[39:32] = ser_hi_merge[7:0];
                    end
                end
                `TTF_OFF_FAMILY: begin
                    rdata_next[7:0]                 = family_reg;
                    rdata_next[`TTF_FAMILY_LOCK_BIT] = locked_reg;
                end
                `TTF_OFF_REPLY: begin
                    rdata_next[2:0]  = status_reg[2:0];
                    rdata_next[15:8] = status_reg[10:3];
                end
                default: begin
                    rdata_next = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (!RESET_N_IN) begin
            ctrl_reg      <= `TTF_CTRL_RESET;
            serial_id_reg <= `TTF_SERIAL_RESET;
            ack_reg       <= 1'b0;
            rdata_reg     <= 32'h0000_0000;
        end else begin
            ctrl_reg      <= ctrl_next;
            serial_id_reg <= serial_id_next;
            ack_reg       <= ack_next;
            rdata_reg     <= rdata_next;
        end
    end

    assign WB_ACK_OUT        = ack_reg;
    assign WB_DAT_OUT        = rdata_reg;
    assign FAMILY_OUT        = family_reg;
    assign FAMILY_LOCKED_OUT = locked_reg;
endmodule
`default_nettype wire

//--- testbench/ttf_family_cmd_sva.sv
`timescale 1ns/1ns
`default_nettype none
module ttf_family_cmd_sva (
    // clock and reset
    input wire logic                   CORE_CLK_IN,
    input wire logic                   RESET_N_IN,
    // watched ports
    input wire logic                   WB_CYC_IN,
    input wire logic                   WB_STB_IN,
    input wire logic                   WB_ACK_OUT,
    input wire ttf_pkg::ttf_frame_in_s FRAME_IN,
    input wire logic                   REPLY_VALID_OUT,
    input wire ttf_pkg::ttf_reply_s    REPLY_OUT,
    input wire logic [7:0]             FAMILY_OUT,
    input wire logic                   FAMILY_LOCKED_OUT
);
    import ttf_pkg::*;
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RESET_N_IN);

    a_ack_after_req: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT)
        else $error("ack missing");
    a_ack_single: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
        else $error("ack longer than one cycle");
    a_reply_needs_frame: assert property (REPLY_VALID_OUT |-> $past(FRAME_IN.frame_end, 2))
        else $error("reply without frame end two cycles before");
    a_reply_pulse_holds: assert property (!REPLY_VALID_OUT |-> $stable(REPLY_OUT))
        else $error("reply changed without pulse");
    a_error_has_code: assert property (REPLY_VALID_OUT && REPLY_OUT.error |-> REPLY_OUT.code != 8'h00)
        else $error("error reply without code");
    a_family_needs_ok: assert property (!$stable(FAMILY_OUT) |-> REPLY_VALID_OUT && !REPLY_OUT.error)
        else $error("family changed without success reply");
    a_lock_needs_ok: assert property ($rose(FAMILY_LOCKED_OUT) |-> REPLY_VALID_OUT && !REPLY_OUT.error)
        else $error("lock set without success reply");
    a_lock_sticky: assert property (FAMILY_LOCKED_OUT |=> FAMILY_LOCKED_OUT)
        else $error("lock flag cleared");
    a_family_frozen: assert property (FAMILY_LOCKED_OUT |=> $stable(FAMILY_OUT))
        else $error("locked family changed");
endmodule

bind ttf_family_cmd ttf_family_cmd_sva ttf_family_cmd_sva_inst (.CORE_CLK_IN, .RESET_N_IN, .WB_CYC_IN,
    .WB_STB_IN, .WB_ACK_OUT, .FRAME_IN, .REPLY_VALID_OUT, .REPLY_OUT, .FAMILY_OUT, .FAMILY_LOCKED_OUT);
`default_nettype wire

//--- testbench/ttf_reader_model.sv
`timescale 1ns/1ns
`default_nettype none
`include "ttf_params.svh"
module ttf_reader_model (
    // clock
    input  wire logic              clk_in,
    // demodulated frame
    output ttf_pkg::ttf_frame_in_s frame_out
);
    import ttf_pkg::*;
    initial frame_out = '0;

    task automatic send(input logic [5:0] c, input logic f, input logic [39:0] s, input logic [7:0] d,
                        input logic h, input int gap);
        logic [79:0] v;
        int          n;
        logic        wr;
        wr = (c == `TTF_CMD_WRITE_FAMILY);
        // header, serial, family byte, crc as the format asks
        v = {64'h0, 1'b0, c, f, 8'h00};
        n = 16;
        v = f ? {v[39:0], s} : v;
        n += f ? 40 : 0;
        v = wr ? {v[71:0], d} : v;
        n += wr ? 8 : 0;
        v = (wr || f) ? {v[63:0], 16'h0000} : v;
        n += (wr || f) ? 16 : 0;
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge clk_in);
            frame_out.bit_valid <= 1'b1;
            frame_out.bit_data  <= v[i];
            @(posedge clk_in);
            frame_out.bit_valid <= 1'b0;
            // idle line shows the inverse so a stale bit never looks valid
            frame_out.bit_data  <= ~v[i];
            repeat (gap) @(posedge clk_in);
        end
        @(posedge clk_in);
        frame_out.frame_end   <= 1'b1;
        frame_out.hdr_crc_ok  <= h;
        frame_out.body_crc_ok <= 1'b1;
        @(posedge clk_in);
        frame_out.frame_end   <= 1'b0;
        frame_out.hdr_crc_ok  <= 1'b0;
        frame_out.body_crc_ok <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- testbench/ttf_family_cmd_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "ttf_params.svh"
module ttf_family_cmd_tb;
    import ttf_pkg::*;
    localparam logic [39:0] SER  = 40'h5A_A5C3_0F1E;
    localparam logic [5:0]  WR   = `TTF_CMD_WRITE_FAMILY;
    localparam logic [5:0]  LK   = `TTF_CMD_LOCK_FAMILY;
    localparam logic [9:0]  OK   = 10'h200;
    localparam logic [9:0]  SIL  = 10'h000;
    localparam logic [9:0]  NSUP = {2'b11, `TTF_ERR_NOT_SUPPORTED};
    localparam logic [9:0]  LKD  = {2'b11, `TTF_ERR_LOCKED};
    logic           clk;
    logic           rst_n;
    logic           cyc;
    logic           stb;
    logic           we;
    logic [7:0]     adr;
    logic [3:0]     sel;
    logic [31:0]    wdat;
    logic [31:0]    rdat;
    logic           ack;
    ttf_frame_in_s  frm;
    ttf_tag_state_e st;
    logic           rvalid;
    ttf_reply_s     reply;
    logic [7:0]     fam;
    logic           locked;
    logic [7:0]     fam_exp;
    logic           lock_exp;
    logic [31:0]    q;
    int             fail_count;
    int             n_compared;
    ttf_tag_state_e nsel [4] = '{TTF_READY, TTF_QUIET, TTF_ROUND_ACTIVE, TTF_ROUND_STANDBY};

    ttf_family_cmd ttf_family_cmd_inst (.CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .WB_CYC_IN(cyc),
        .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
        .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .FRAME_IN(frm), .TAG_STATE_IN(st),
        .REPLY_VALID_OUT(rvalid), .REPLY_OUT(reply), .FAMILY_OUT(fam), .FAMILY_LOCKED_OUT(locked));
    ttf_reader_model ttf_reader_model_inst (.clk_in(clk), .frame_out(frm));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic complete_run();
        if (fail_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
        int k;
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 50);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            fail_count++;
            complete_run();
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string what);
        logic [31:0] r;
        wb(a, 1'b0, 32'h0, r);
        check_val(r, e, what);
    endtask

    task automatic frame(input logic [5:0] c, input logic f, input logic [39:0] s, input logic [7:0] d,
                         input ttf_tag_state_e t, input logic h, input int gap, input logic [9:0] e);
        @(posedge clk);
        st <= t;
        ttf_reader_model_inst.send(c, f, s, d, h, gap);
        // reply lands two edges after the frame end edge
        @(posedge clk);
        @(negedge clk);
        check_val(rvalid, e[9], "reply pulse");
        if (e[9]) check_val(reply, e[8:0], "reply word");
        if (e[9:8] == 2'b10 && c == WR) fam_exp = d;
        if (e[9:8] == 2'b10 && c == LK) lock_exp = 1'b1;
        check_val(fam, fam_exp, "family");
        check_val(locked, lock_exp, "lock flag");
    endtask

    initial begin
        rst_n = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'hF;
        wdat = 32'h0;
        st = TTF_READY;
        fail_count = 0;
        n_compared = 0;
        fam_exp = 8'h00;
        lock_exp = 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(`TTF_OFF_CTRL, 32'h0000_0003, "ctrl reset");
        rd_chk(`TTF_OFF_SERIAL_LO, 32'h0, "serial reset");
        wb(8'h40, 1'b1, 32'hFFFF_FFFF, q);
        rd_chk(8'h40, 32'h0, "unmapped");
        wb(`TTF_OFF_FAMILY, 1'b1, 32'h0000_01FF, q);
        rd_chk(`TTF_OFF_FAMILY, 32'h0, "family read only");
        wb(`TTF_OFF_SERIAL_LO, 1'b1, SER[31:0], q);
        wb(`TTF_OFF_SERIAL_HI, 1'b1, {24'h0, SER[39:32]}, q);
        rd_chk(`TTF_OFF_SERIAL_HI, {24'h0, SER[39:32]}, "serial hi");
        foreach (nsel[i]) begin
            frame(WR, 1'b1, SER ^ 40'h1, 8'h11, nsel[i], 1'b1, 0, SIL);
            frame(WR, 1'b0, SER, 8'h22, nsel[i], 1'b1, 0, SIL);
            frame(WR, 1'b1, SER, 8'h30 | 8'(i), nsel[i], 1'b1, i, OK);
        end
        frame(WR, 1'b0, SER, 8'h44, TTF_SELECTED, 1'b0, 0, SIL);
        frame(WR, 1'b0, SER, 8'h3C, TTF_SELECTED, 1'b1, 1, OK);
        frame(WR, 1'b1, SER ^ 40'h80_0000_0000, 8'h55, TTF_SELECTED, 1'b1, 0, SIL);
        frame(WR, 1'b1, SER, 8'hC3, TTF_SELECTED, 1'b1, 0, OK);
        wb(`TTF_OFF_CTRL, 1'b1, 32'h0000_0002, q);
        frame(WR, 1'b0, SER, 8'h99, TTF_SELECTED, 1'b1, 0, NSUP);
        wb(`TTF_OFF_CTRL, 1'b1, 32'h0000_0001, q);
        frame(LK, 1'b1, SER, 8'h00, TTF_QUIET, 1'b1, 0, NSUP);
        wb(`TTF_OFF_CTRL, 1'b1, 32'h0000_0003, q);
        frame(LK, 1'b0, SER, 8'h00, TTF_QUIET, 1'b1, 0, SIL);
        frame(LK, 1'b0, SER, 8'h00, TTF_SELECTED, 1'b1, 0, OK);
        frame(WR, 1'b0, SER, 8'h77, TTF_SELECTED, 1'b1, 0, LKD);
        frame(LK, 1'b1, SER, 8'h00, TTF_ROUND_ACTIVE, 1'b1, 0, LKD);
        rd_chk(`TTF_OFF_REPLY, 32'h0000_0F03, "reply status");
        rd_chk(`TTF_OFF_FAMILY, 32'h0000_01C3, "family reg");
        complete_run();
    end
endmodule
`default_nettype wire
